// ### ampi_mem_if.v
// asynchronous external memory pin interface with shared pin functions
`timescale 1ns/10ps
module ampi_mem_if (
  core_clk,
  reset_n,
  accReq,
  accWrite,
  accAddr,
  accWdata,
  accBusy_r,
  accDone_r,
  accRdata_r,
  bootMode,
  dataSel,
  pdapEn,
  flag2Sel,
  flag3Sel,
  flagOutEn,
  flagOutVal,
  timerExpired,
  pwmOut,
  extAddrOut_r,
  extAddrOe_r,
  extDataIn,
  extDataOut_r,
  extDataOe_r,
  extWaitAckIn,
  bankChipSelectN_r,
  bankChipSelectOe_r,
  extReadStrobeN_r,
  extWriteStrobeN_r,
  strobeOe_r,
  flagPinIn,
  flagPinOut_r,
  flagPinOe_r,
  flagIn_r,
  pdapAddr_r,
  pdapData_r
);
  `include "ampi_regs.vh"
  input wire core_clk; // core clock, 250 MHz
  input wire reset_n; // synchronous reset, active low
  input wire accReq; // core access request (conditional too)
  input wire accWrite; // high write, low read
  input wire [23:0] accAddr; // access address
  input wire [7:0] accWdata; // write data
  output reg accBusy_r; // access in progress
  output reg accDone_r; // one-cycle completion pulse
  output reg [7:0] accRdata_r; // read data
  input wire [2:0] bootMode; // boot configuration code
  input wire [1:0] dataSel; // data pin function
  input wire pdapEn; // parallel input control enable
  input wire [1:0] flag2Sel; // flag pin 2 function
  input wire [1:0] flag3Sel; // flag pin 3 function
  input wire [3:0] flagOutEn; // flag directions
  input wire [3:0] flagOutVal; // flag output levels
  input wire timerExpired; // timer expired event level
  input wire [7:0] pwmOut; // pulse-width outputs
  output reg [23:0] extAddrOut_r; // address pins
  output reg extAddrOe_r; // address pins driven
  input wire [7:0] extDataIn; // data pins level
  output reg [7:0] extDataOut_r; // data pins drive
  output reg [7:0] extDataOe_r; // data pins enables
  input wire extWaitAckIn; // acknowledge, low adds wait states
  output reg [1:0] bankChipSelectN_r; // bank 0/1 selects
  output reg bankChipSelectOe_r; // selects driven
  output reg extReadStrobeN_r; // read strobe, active low
  output reg extWriteStrobeN_r; // write strobe, active low
  output reg strobeOe_r; // strobes driven
  input wire [3:0] flagPinIn; // flag pins level
  output reg [3:0] flagPinOut_r; // flag pins drive
  output reg [3:0] flagPinOe_r; // flag pins enables
  output reg [3:0] flagIn_r; // sampled flag pins
  output reg [23:0] pdapAddr_r; // parallel input address: core address while enabled, else the driven address
  output reg [7:0] pdapData_r; // parallel input from data pins
  // ---------------------------------------------------------------
  // state machine
  // ---------------------------------------------------------------
  localparam ST_IDLE = 3'b001; // no access
  localparam ST_SETUP = 3'b010; // address and select out
  localparam ST_STROBE = 3'b100; // strobe held until acknowledge
  reg [2:0] state_r; // current state
  reg writeAcc_r; // current access is a write
  reg [1:0] bankSel_r; // decoded bank of current access
  reg emifLive_r; // pins out of reset into memory function
  wire [1:0] reqBank; // bank of requested address
  wire emifData; // data pins in memory function
  wire [3:0] msN; // all four bank selects
  wire [3:0] flagPinOut; // per pin drive
  wire [3:0] flagPinOe; // per pin enable
  wire [3:0] flagSample; // per pin sample
  wire [1:0] fsel [0:3]; // per pin function
  reg [7:0] wrData_r; // write byte held for the whole access
  wire accTake; // request accepted at this edge
  wire accEnd; // acknowledge high under the strobe
  assign reqBank = accAddr[`AMPI_BANK_HI:`AMPI_BANK_LO];
  assign emifData = (dataSel == `AMPI_DSEL_EXTERNAL_MEMORY_FUNCTION);
  assign accTake = (state_r == ST_IDLE) && accReq && !pdapEn;
  assign accEnd = (state_r == ST_STROBE) && extWaitAckIn;
  // selects move with the address at take, drop at the end
  // bank selects decode the address only, bootMode is not used
  assign msN = accTake ? ~(4'h1 << reqBank) :
    (accEnd || state_r == ST_IDLE) ? 4'hf :
    ~(4'h1 << bankSel_r);
  assign fsel[0] = `AMPI_FSEL_FLAG;
  assign fsel[1] = `AMPI_FSEL_FLAG;
  assign fsel[2] = flag2Sel;
  assign fsel[3] = flag3Sel;
  // ---------------------------------------------------------------
  // access sequencing
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      writeAcc_r <= 1'b0;
      bankSel_r <= 2'h0;
      emifLive_r <= 1'b0;
      accBusy_r <= 1'b0;
      accDone_r <= 1'b0;
      accRdata_r <= 8'h00;
      wrData_r <= 8'h00;
      extAddrOut_r <= 24'h000000;
      extReadStrobeN_r <= 1'b1;
      extWriteStrobeN_r <= 1'b1;
    end else begin
      emifLive_r <= 1'b1; // memory function after reset
      accDone_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          // conditional accesses still request and select
          if (accTake) begin
            extAddrOut_r <= accAddr;
            wrData_r <= accWdata; // core need not hold the byte
            bankSel_r <= reqBank;
            writeAcc_r <= accWrite;
            accBusy_r <= 1'b1;
            state_r <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          extReadStrobeN_r <= writeAcc_r;
          extWriteStrobeN_r <= ~writeAcc_r;
          state_r <= ST_STROBE;
        end
        ST_STROBE: begin
          // hold while acknowledge is low
          if (extWaitAckIn) begin
            extReadStrobeN_r <= 1'b1;
            extWriteStrobeN_r <= 1'b1;
            if (!writeAcc_r) begin
              accRdata_r <= extDataIn;
            end
            accBusy_r <= 1'b0;
            accDone_r <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
  // ---------------------------------------------------------------
  // pin enables and shared pin functions
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!reset_n) begin
      extAddrOe_r <= 1'b0;
      extDataOut_r <= 8'h00;
      extDataOe_r <= 8'h00;
      bankChipSelectN_r <= 2'h3;
      bankChipSelectOe_r <= 1'b0; // float during reset
      strobeOe_r <= 1'b0;
      pdapAddr_r <= 24'h000000;
      pdapData_r <= 8'h00;
    end else begin
      bankChipSelectN_r <= msN[1:0];
      bankChipSelectOe_r <= emifLive_r;
      strobeOe_r <= emifLive_r;
      // address pins become inputs for parallel input
      extAddrOe_r <= emifLive_r && !pdapEn;
      pdapAddr_r <= extAddrOut_r;
      if (pdapEn) begin
        pdapAddr_r <= accAddr; // no address pin input: core address
      end
      pdapData_r <= extDataIn;
      // one data pin function at a time
      case (dataSel)
        `AMPI_DSEL_EXTERNAL_MEMORY_FUNCTION: begin
          extDataOut_r <= wrData_r;
          extDataOe_r <= (emifData && writeAcc_r &&
            state_r != ST_IDLE) ? 8'hff : 8'h00;
        end
        `AMPI_DSEL_FLAG: begin
          extDataOut_r <= {4'h0, flagOutVal};
          extDataOe_r <= {4'h0, flagOutEn};
        end
        `AMPI_DSEL_PWM: begin
          extDataOut_r <= pwmOut;
          extDataOe_r <= 8'hff;
        end
        default: begin
          extDataOut_r <= 8'h00;
          extDataOe_r <= 8'h00;
        end
      endcase
    end
  end
  // ---------------------------------------------------------------
  // flag pins, two carry alternate bank selects
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : gFlag
      ampi_flag_pin uPin (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .funcSel(fsel[gi]),
        .flagOutEn(flagOutEn[gi]),
        .flagOutVal(flagOutVal[gi]),
        .altOut(timerExpired),
        .altIsOutput(gi == 3),
        .msN(msN[gi]),
        .pinIn(flagPinIn[gi]),
        .pinOut_r(flagPinOut[gi]),
        .pinOe_r(flagPinOe[gi]),
        .flagIn_r(flagSample[gi])
      );
    end
  endgenerate
  // ---------------------------------------------------------------
  // register the flag outputs at the top
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!reset_n) begin
      flagPinOut_r <= 4'hf;
      flagPinOe_r <= 4'h0;
      flagIn_r <= 4'h0;
    end else begin
      flagPinOut_r[1:0] <= flagPinOut[1:0];
      // bank 2/3 selects skip the pin stage to stay with the address
      flagPinOut_r[2] <= (flag2Sel == `AMPI_FSEL_MS) ? msN[2] :
        flagPinOut[2];
      flagPinOut_r[3] <= (flag3Sel == `AMPI_FSEL_MS) ? msN[3] :
        flagPinOut[3];
      flagPinOe_r <= flagPinOe;
      flagIn_r <= flagSample;
    end
  end
endmodule // ampi_mem_if

// ### ampi_regs.vh
// constants for the asynchronous memory pin interface
`ifndef AMPI_REGS_VH
`define AMPI_REGS_VH
// ---------------------------------------------------------------
// widths
// ---------------------------------------------------------------
`define AMPI_ADDR_W 24
`define AMPI_DATA_W 8
// bank field: address bits 23:22 select one of four banks
`define AMPI_BANK_HI 23
`define AMPI_BANK_LO 22
// ---------------------------------------------------------------
// data pin function selections
// ---------------------------------------------------------------
`define AMPI_DSEL_EXTERNAL_MEMORY_FUNCTION 2'h0
`define AMPI_DSEL_PARALLEL_DATA_ACQUISITION 2'h1
`define AMPI_DSEL_FLAG 2'h2
`define AMPI_DSEL_PWM 2'h3
// ---------------------------------------------------------------
// flag pin 2/3 function selections
// ---------------------------------------------------------------
`define AMPI_FSEL_FLAG 2'h0
`define AMPI_FSEL_ALT 2'h1
`define AMPI_FSEL_MS 2'h2
// ---------------------------------------------------------------
// boot mode code for 8-bit flash boot over this port
// ---------------------------------------------------------------
`define AMPI_BOOT_FLASH 3'h2
`endif

// ### ampi_flag_pin.v
// one general flag pin with alternate output and bank select functions
`timescale 1ns/10ps
module ampi_flag_pin (
  core_clk,
  reset_n,
  funcSel,
  flagOutEn,
  flagOutVal,
  altOut,
  altIsOutput,
  msN,
  pinIn,
  pinOut_r,
  pinOe_r,
  flagIn_r
);
  `include "ampi_regs.vh"
  input wire core_clk; // core clock
  input wire reset_n; // synchronous reset, active low
  input wire [1:0] funcSel; // flag, alternate, or bank select
  input wire flagOutEn; // flag direction, high drives
  input wire flagOutVal; // flag output level
  input wire altOut; // alternate output (timer expired)
  input wire altIsOutput; // alternate function drives the pin
  input wire msN; // bank select for this pin, active low
  input wire pinIn; // pin level
  output reg pinOut_r; // pin drive level
  output reg pinOe_r; // pin output enable
  output reg flagIn_r; // sampled pin level (flag or irq input)
  // -------------------------------------------------------------
  // pin drive selection
  // -------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!reset_n) begin
      pinOut_r <= 1'b1;
      pinOe_r <= 1'b0; // pin is an input after reset
      flagIn_r <= 1'b0;
    end else begin
      flagIn_r <= pinIn;
      case (funcSel)
        `AMPI_FSEL_MS: begin // chip select for extra bank
          pinOut_r <= msN;
          pinOe_r <= 1'b1;
        end
        `AMPI_FSEL_ALT: begin // irq input or timer-expired output
          pinOut_r <= altOut;
          pinOe_r <= altIsOutput;
        end
        default: begin // general flag
          pinOut_r <= flagOutVal;
          pinOe_r <= flagOutEn;
        end
      endcase
    end
  end
endmodule // ampi_flag_pin

// ### ampi_mem_if_asserts.sv
// concurrent checks on the memory pin interface ports
`timescale 1ns/10ps
module ampi_mem_if_asserts (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic accReq,
  input wire logic accWrite,
  input wire logic [23:0] accAddr,
  input wire logic accBusy_r,
  input wire logic accDone_r,
  input wire logic pdapEn,
  input wire logic [1:0] flag2Sel,
  input wire logic [1:0] flag3Sel,
  input wire logic [23:0] extAddrOut_r,
  input wire logic extAddrOe_r,
  input wire logic extWaitAckIn,
  input wire logic [1:0] bankChipSelectN_r,
  input wire logic bankChipSelectOe_r,
  input wire logic extReadStrobeN_r,
  input wire logic extWriteStrobeN_r,
  input wire logic strobeOe_r,
  input wire logic [3:0] flagPinOut_r,
  input wire logic [3:0] flagPinOe_r
);
  // ---------------------------------------------------------------
  // helper logic
  // ---------------------------------------------------------------
  logic [1:0] upCnt_r; // edges since reset release, saturating
  logic take; // a request the interface must accept
  logic strobeLow; // either strobe asserted
  always @(posedge core_clk) begin
    if (!reset_n) upCnt_r <= 2'h0;
    else if (upCnt_r != 2'h3) upCnt_r <= upCnt_r + 2'h1;
  end
  assign take = accReq && !accBusy_r && !pdapEn && upCnt_r == 2'h3;
  assign strobeLow = !extReadStrobeN_r || !extWriteStrobeN_r;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_addr_drive: assert property (take |=> accBusy_r && extAddrOe_r
    && extAddrOut_r == $past(accAddr)) else $error("address not driven");
  a_min_latency: assert property (take |=> !accDone_r [*2])
    else $error("access ended too early");
  a_done_bound: assert property (take |-> ##[2:24] accDone_r)
    else $error("access never completed");
  a_wait_hold: assert property (strobeLow && !extWaitAckIn
    |=> strobeLow && !accDone_r) else $error("wait state ignored");
  a_rd_strobe: assert property (take && !accWrite
    |=> ##[0:2] !extReadStrobeN_r && extWriteStrobeN_r)
    else $error("read strobe missing");
  a_wr_strobe: assert property (take && accWrite
    |=> ##[0:2] !extWriteStrobeN_r && extReadStrobeN_r)
    else $error("write strobe missing");
  a_one_sel: assert property (bankChipSelectN_r != 2'h0)
    else $error("two bank selects active");
  a_sel_decode: assert property (bankChipSelectN_r != 2'h3 |->
    !extAddrOut_r[23] && !bankChipSelectN_r[extAddrOut_r[22]])
    else $error("bank select not from address");
  a_sel_idle: assert property (!accBusy_r && !$past(accBusy_r)
    && !$past(accBusy_r, 2) |-> bankChipSelectN_r == 2'h3)
    else $error("bank select active while idle");
  a_flag_bank: assert property (flag2Sel == 2'h2 && flagPinOe_r[2]
    && !flagPinOut_r[2] |-> extAddrOut_r[23:22] == 2'h2)
    else $error("flag 2 select on wrong bank");
  a_flag3_bank: assert property (flag3Sel == 2'h2 && flagPinOe_r[3]
    && !flagPinOut_r[3] |-> extAddrOut_r[23:22] == 2'h3)
    else $error("flag 3 select on wrong bank");
  a_reset_float: assert property (disable iff (1'b0) !reset_n
    |=> !bankChipSelectOe_r && !strobeOe_r && flagPinOe_r == 4'h0)
    else $error("pins driven in reset");
  // main scenarios reached
  c_read_wait: cover property (take && !accWrite ##2 !extWaitAckIn);
  c_write: cover property (take && accWrite);
  c_flag_bank: cover property (flagPinOe_r[2] && !flagPinOut_r[2]);
endmodule // ampi_mem_if_asserts
bind ampi_mem_if ampi_mem_if_asserts ampi_mem_if_asserts_i (.core_clk,
  .reset_n, .accReq, .accWrite, .accAddr, .accBusy_r, .accDone_r, .pdapEn,
  .flag2Sel, .flag3Sel, .extAddrOut_r, .extAddrOe_r, .extWaitAckIn,
  .bankChipSelectN_r,
  .bankChipSelectOe_r, .extReadStrobeN_r, .extWriteStrobeN_r, .strobeOe_r,
  .flagPinOut_r, .flagPinOe_r);

// ### ampi_mem_partner.sv
// behavioural external byte memory with programmable wait states
`timescale 1ns/10ps
module ampi_mem_partner (
  input wire logic core_clk,
  input wire logic rdN, // read strobe, active low
  input wire logic wrN, // write strobe, active low
  input wire logic [23:0] addr, // address pins
  input wire logic [7:0] dOut, // device data drive
  input wire logic [7:0] dOe, // device data enables
  input wire logic [2:0] waitCnt, // wait states for this access
  output logic [7:0] dIn, // resolved data wire
  output logic ack, // acknowledge, low holds the access
  output logic [7:0] lastWr // byte last seen during a write
);
  logic [2:0] cnt_r = 3'h0; // cycles spent under a strobe
  logic [7:0] pad; // memory drive, pull-up level when released
  wire act = !rdN || !wrN;
  // ack low until the wait count has run out
  assign ack = !(act && cnt_r < waitCnt);
  assign pad = !rdN ? (addr[7:0] ^ 8'h5a) : 8'hff;
  assign dIn = (dOe & dOut) | (~dOe & pad);
  // count wait cycles and capture write data
  always @(posedge core_clk) begin
    if (!act) cnt_r <= 3'h0;
    else if (cnt_r != 3'h7) cnt_r <= cnt_r + 3'h1;
    if (!wrN) lastWr <= dIn;
  end
endmodule // ampi_mem_partner

// ### ampi_mem_if_tb.sv
// self-checking bench for the memory pin interface
`timescale 1ns/10ps
`include "ampi_regs.vh"
module ampi_mem_if_tb;
  reg core_clk, reset_n, accReq, accWrite, pdapEn, timerExpired;
  reg [23:0] accAddr;
  reg [7:0] accWdata, pwmOut, lastExp;
  reg [3:0] flagOutVal, flagOutEn;
  reg [1:0] dataSel, flag2Sel, flag3Sel;
  reg [2:0] waitCnt;
  reg [31:0] seed;
  reg [8:0] e;
  reg [8:0] expQ[$]; // queued results: write flag and byte
  integer err_total, n_checks, i;
  wire accBusy_r, accDone_r, extAddrOe_r, extWaitAckIn, bankChipSelectOe_r;
  wire extReadStrobeN_r, extWriteStrobeN_r, strobeOe_r;
  wire [7:0] accRdata_r, extDataIn, extDataOut_r, extDataOe_r, lastWr;
  wire [23:0] extAddrOut_r;
  wire [1:0] bankChipSelectN_r;
  wire [3:0] flagPinIn, flagPinOut_r, flagPinOe_r;
  wire [3:0] flagIn_r;
  wire [23:0] pdapAddr_r;
  wire [7:0] pdapData_r;
  // released flag pins sit at the pull-up level
  assign flagPinIn = (flagPinOe_r & flagPinOut_r) | ~flagPinOe_r;
  ampi_mem_if ampi_mem_if_i (.core_clk, .reset_n, .accReq, .accWrite,
    .accAddr, .accWdata, .accBusy_r, .accDone_r, .accRdata_r,
    .bootMode(`AMPI_BOOT_FLASH), .dataSel, .pdapEn, .flag2Sel, .flag3Sel,
    .flagOutEn, .flagOutVal, .timerExpired, .pwmOut, .extAddrOut_r,
    .extAddrOe_r,
    .extDataIn, .extDataOut_r, .extDataOe_r, .extWaitAckIn,
    .bankChipSelectN_r, .bankChipSelectOe_r, .extReadStrobeN_r,
    .extWriteStrobeN_r, .strobeOe_r, .flagPinIn, .flagPinOut_r,
    .flagPinOe_r, .flagIn_r, .pdapAddr_r, .pdapData_r);
  ampi_mem_partner ampi_mem_partner_i (.core_clk(core_clk),
    .rdN(extReadStrobeN_r), .wrN(extWriteStrobeN_r), .addr(extAddrOut_r),
    .dOut(extDataOut_r), .dOe(extDataOe_r), .waitCnt(waitCnt),
    .dIn(extDataIn), .ack(extWaitAckIn), .lastWr(lastWr));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic [31:0] xs(input [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task chk(input [23:0] seen, input [23:0] want);
    n_checks++;
    if (seen !== want) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one access; expected result goes on the queue
  task acc(input w, input [23:0] a, input [7:0] d, input [2:0] wt);
    integer n;
    @(posedge core_clk);
    accReq <= 1'b1;
    accWrite <= w;
    accAddr <= a;
    accWdata <= d;
    waitCnt <= wt;
    expQ.push_back({w, w ? d : (a[7:0] ^ 8'h5a)});
    @(posedge core_clk);
    accReq <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (accDone_r !== 1'b1 && n < 40);
  endtask
  // ---------------------------------------------------------------
  // processes
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // result watcher: oldest note against each completion
  always @(posedge core_clk) begin
    if (accDone_r === 1'b1) begin
      if (expQ.size() == 0) chk(24'h1, 24'h0);
      else begin
        e = expQ.pop_front();
        if (e[8]) chk(lastWr, e[7:0]);
        else chk(accRdata_r, e[7:0]);
      end
    end
  end
  initial begin
    repeat (4000) @(posedge core_clk);
    err_total++;
    give_verdict;
  end
  initial begin
    {reset_n, accReq, accWrite, pdapEn, timerExpired} = 5'h0;
    {accAddr, accWdata, pwmOut, flagOutVal, flagOutEn, waitCnt} = 0;
    dataSel = `AMPI_DSEL_EXTERNAL_MEMORY_FUNCTION;
    flag2Sel = `AMPI_FSEL_FLAG;
    flag3Sel = `AMPI_FSEL_FLAG;
    seed = 32'd58627;
    err_total = 0;
    n_checks = 0;
    repeat (8) @(posedge core_clk);
    chk(extDataOe_r, 24'h0);
    chk({bankChipSelectOe_r, strobeOe_r, flagPinOe_r}, 24'h0);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    // memory pins driven, flags still plain undriven flags
    chk({extAddrOe_r, strobeOe_r, flagPinOe_r}, 24'h30);
    chk(bankChipSelectOe_r, 24'h1);
    flag2Sel <= `AMPI_FSEL_MS;
    flag3Sel <= `AMPI_FSEL_MS;
    seed = xs(seed);
    pwmOut <= seed[7:0];
    flagOutVal <= seed[11:8];
    timerExpired <= seed[12];
    // every bank, both directions, random waits
    for (i = 0; i < 32; i++) begin
      seed = xs(seed);
      acc(seed[0], {(i < 4) ? i[1:0] : seed[31:30], seed[21:0]},
        seed[29:22], seed[3:1]);
    end
    // requests refused while parallel input owns the pins
    pdapEn <= 1'b1;
    accReq <= 1'b1;
    repeat (6) begin
      @(posedge core_clk);
      chk(accBusy_r, 24'h0);
      chk(extAddrOut_r, accAddr);
    end
    chk(extAddrOe_r, 24'h0);
    accReq <= 1'b0;
    pdapEn <= 1'b0;
    @(posedge core_clk);
    chk(expQ.size(), 24'h0);
    // shared pins: pwm on data, timer on flag 3, then plain flags
    dataSel <= `AMPI_DSEL_PWM;
    flag3Sel <= `AMPI_FSEL_ALT;
    repeat (3) @(posedge core_clk);
    chk(extDataOe_r, 24'hff);
    chk(extDataOut_r, pwmOut);
    chk(pdapData_r, pwmOut);
    chk(pdapAddr_r, accAddr);
    chk({flagPinOe_r[3], flagPinOut_r[3]}, {1'b1, timerExpired});
    seed = xs(seed);
    dataSel <= `AMPI_DSEL_FLAG;
    flag2Sel <= `AMPI_FSEL_FLAG;
    flagOutEn <= seed[3:0];
    repeat (5) @(posedge core_clk);
    chk(extDataOe_r, {4'h0, flagOutEn});
    chk(extDataOut_r, {4'h0, flagOutVal});
    chk(flagPinOe_r[2:0], flagOutEn[2:0]);
    chk(flagPinOut_r[2:0], flagOutVal[2:0]);
    chk(flagIn_r[2:0], {flagOutVal[2:0] | ~flagOutEn[2:0]});
    chk(flagIn_r[3], timerExpired);
    give_verdict;
  end
endmodule // ampi_mem_if_tb
